// ==== sbu_pkg.sv ====
`default_nettype none
package sbu_pkg;
  localparam logic [15:0] FLASH_BASE = 16'hC000;
  localparam logic [15:0] BOOT_BASE = 16'hF800;
  localparam logic [15:0] RAM_BASE = 16'h0040;
  localparam int RAM_BYTES = 512;
  localparam logic [7:0] SYNC_BYTE = 8'h5A;
  localparam logic [7:0] BAUD_76800 = 8'h04;
  localparam logic [7:0] BAUD_62500 = 8'h05;
  localparam logic [7:0] BAUD_38400 = 8'h07;
  localparam logic [7:0] BAUD_31250 = 8'h0A;
  localparam logic [7:0] BAUD_19200 = 8'h18;
  localparam logic [7:0] BAUD_9600 = 8'h28;
  localparam logic [7:0] CMD_FLASH_WR = 8'h30;
  localparam logic [7:0] CMD_RAM_LOAD = 8'h60;
  localparam logic [7:0] CMD_FLASH_SUM = 8'h90;
  localparam int DIV_W = 11;
  // oscillator cycles per bit at 16 MHz; lower frequencies shift right
  localparam logic [DIV_W-1:0] DIV16_76800 = 11'd208;
  localparam logic [DIV_W-1:0] DIV16_62500 = 11'd256;
  localparam logic [DIV_W-1:0] DIV16_38400 = 11'd416;
  localparam logic [DIV_W-1:0] DIV16_31250 = 11'd512;
  localparam logic [DIV_W-1:0] DIV16_19200 = 11'd832;
  localparam logic [DIV_W-1:0] DIV16_9600 = 11'd1664;
  localparam logic [4:0] OSC_2MHZ = 5'd2;
  localparam logic [4:0] OSC_4MHZ = 5'd4;
  localparam logic [4:0] OSC_8MHZ = 5'd8;
  localparam logic [4:0] OSC_16MHZ = 5'd16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FRAME_LAST_BIT = 4'd9;
  localparam logic [3:0] ERR_RST_CYCLES = 4'd8;
  typedef enum logic [2:0] {ST_SYNC, ST_BAUD, ST_CMD, ST_RUN, ST_MUTE} sbu_state_e;
endpackage
`default_nettype wire

// ==== sbu_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sbu_stream_if #(parameter int W = 8) ();
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport buffer (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// ==== sbu_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module sbu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  sbu_stream_if.buffer s
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sbu_fifo_s;
  sbu_fifo_s st_r;
  sbu_fifo_s st_nxt;
  logic [W-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  assign s.wr_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign s.rd_valid = (st_r.cnt != '0);
  assign s.rd_data = mem[st_r.rp];
  assign do_wr = s.wr_valid && s.wr_ready;
  assign do_rd = s.rd_valid && s.rd_ready;

  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wp = st_r.wp + AW'(1);
    end
    if (do_rd) begin
      st_nxt.rp = st_r.rp + AW'(1);
    end
    if (do_wr && !do_rd) begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[st_r.wp] <= s.wr_data;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    st_r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ==== sbu_top.sv ====
// Function
// [R1] factory mode pin low gives normal operation; board keeps it low.
// [R2] normal operation maps the 16 KB program flash at C000H to FFFFH.
// [R3] programmer should fill unused flash with FFH.
// [R4] device provides 512 bytes of static data memory.
// [R5] 2 KB boot memory at F800H-FFFFH only in serial programming mode.
// [R6] entry: reset low, mode and both boot selects high, settle, release.
// [R7] in serial mode boot select a is receive, boot select b transmit.
// [R8] controller sends 5AH after reset release and setup wait.
// [R9] frames: 8 data bits, no parity, 1 stop bit; default 9600 bps.
// [R10] controller uses the same frame format and rate as the device.
// [R11] codes 04H, 05H, 07H select 76800, 62500, 38400 bps.
// [R12] codes 0AH, 18H, 28H select 31250, 19200, 9600 bps.
// [R13] serial mode only at 2, 4, 8 or 16 MHz oscillator.
// [R14] available rates depend on oscillator frequency, as tabulated.
// [R15] reset pin is input and also driven on internal error reset.
// [R16] board leaves the serial pins free during programming.
// [R17] first command is 5AH; echoed when matched, silence on error.
// [R18] command bytes 30H, 60H, 90H: flash write, RAM load, checksum.
// [R19] after baud byte exchange, both sides use the new rate.
// [R20] each rate uses an integer oscillator divisor per frequency.
`timescale 1ns/10ps
`default_nettype none
module sbu_top (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic mode_test_in,
  input wire logic boot_select_a_in,
  input wire logic boot_select_b_in,
  output logic boot_select_b_out,
  output logic boot_select_b_oe_n_out,
  input wire logic high_freq_clock_tick_in,
  input wire logic [4:0] high_freq_clock_mhz_in,
  input wire logic err_reset_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n_out,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic [7:0] cpu_rdata_out,
  output logic flash_sel_out,
  output logic boot_sel_out,
  output logic ram_sel_out,
  output logic serial_mode_out,
  output logic osc_unsupported_out,
  output logic [7:0] cmd_out,
  output logic cmd_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  import sbu_pkg::*;
  typedef struct packed {
    logic strap_done;
    logic serial;
    logic osc_bad;
    sbu_state_e st;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_pend;
    logic pend;
    logic rx_busy;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic push_v;
    logic [7:0] push_d;
    logic tx_busy;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
    logic [7:0] cmd;
    logic cmd_v;
    logic [7:0] rxd;
    logic rxd_v;
    logic [3:0] rst_cnt;
    logic flash_sel;
    logic boot_sel;
    logic ram_sel;
    logic run_v;
  } sbu_top_s;
  sbu_top_s st_r;
  sbu_top_s st_nxt;
  logic [7:0] ram [RAM_BYTES];
  logic [7:0] rdata_r;
  logic byte_v;
  logic [7:0] byte_d;
  logic [DIV_W-1:0] code_div;
  sbu_stream_if #(.W(8)) txq ();
  sbu_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .s(txq.buffer)
  );
  // integer divisor per rate and oscillator; zero means not available
  function automatic logic [DIV_W-1:0] div_of(input logic [7:0] code, input logic [4:0] mhz);
    logic [DIV_W-1:0] base;
    case (code)
      BAUD_76800: base = (mhz == OSC_16MHZ) ? DIV16_76800 : '0; // R11 R14
      BAUD_62500: base = (mhz >= OSC_8MHZ) ? DIV16_62500 : '0; // R11 R14
      BAUD_38400: base = (mhz >= OSC_8MHZ) ? DIV16_38400 : '0; // R11 R14
      BAUD_31250: base = (mhz >= OSC_4MHZ) ? DIV16_31250 : '0; // R12 R14
      BAUD_19200: base = (mhz >= OSC_4MHZ) ? DIV16_19200 : '0; // R12 R14
      BAUD_9600: base = DIV16_9600; // R12 R14
      default: base = '0;
    endcase
    case (mhz)
      OSC_16MHZ: div_of = base; // R20
      OSC_8MHZ: div_of = base >> 1; // R20
      OSC_4MHZ: div_of = base >> 2; // R20
      OSC_2MHZ: div_of = base >> 3; // R20
      default: div_of = '0; // R13
    endcase
  endfunction
  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= RAM_BASE) && (a < RAM_BASE + 16'(RAM_BYTES));
  endfunction

  assign code_div = div_of(st_r.rxd, high_freq_clock_mhz_in);
  assign byte_v = st_r.rxd_v;
  assign byte_d = st_r.rxd;
  assign txq.wr_valid = st_r.push_v;
  assign txq.wr_data = st_r.push_d;
  // the serialiser stalls the queue while a frame is on the line
  assign txq.rd_ready = st_r.serial && !st_r.tx_busy;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_v = 1'b0;
    st_nxt.rxd_v = 1'b0;
    st_nxt.run_v = 1'b0;
    // straps are sampled on the first edge after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.serial = mode_test_in && boot_select_a_in && boot_select_b_in; // R1 R6
      st_nxt.osc_bad = (div_of(BAUD_9600, high_freq_clock_mhz_in) == '0); // R13
      st_nxt.st = st_nxt.osc_bad ? ST_MUTE : ST_SYNC; // R13
      st_nxt.div = div_of(BAUD_9600, high_freq_clock_mhz_in); // R9 R20
    end
    st_nxt.flash_sel = (cpu_addr_in >= FLASH_BASE) &&
                       !(st_r.serial && cpu_addr_in >= BOOT_BASE); // R2
    st_nxt.boot_sel = st_r.serial && (cpu_addr_in >= BOOT_BASE); // R5
    st_nxt.ram_sel = in_ram(cpu_addr_in); // R4
    // receiver, timed on oscillator ticks, sampling mid bit
    if (st_r.serial && high_freq_clock_tick_in && st_r.st != ST_MUTE) begin
      if (!st_r.rx_busy) begin
        if (!boot_select_a_in) begin // R7
          st_nxt.rx_busy = 1'b1;
          st_nxt.rx_cnt = st_r.div >> 1;
          st_nxt.rx_bit = '0;
        end
      end else if (st_r.rx_cnt != '0) begin
        st_nxt.rx_cnt = st_r.rx_cnt - DIV_W'(1);
      end else begin
        st_nxt.rx_cnt = st_r.div - DIV_W'(1);
        st_nxt.rx_bit = st_r.rx_bit + 4'h1;
        if (st_r.rx_bit == 4'h0 && boot_select_a_in) begin
          st_nxt.rx_busy = 1'b0;
        end else if (st_r.rx_bit == FRAME_LAST_BIT) begin // R9
          st_nxt.rx_busy = 1'b0;
          st_nxt.rxd_v = boot_select_a_in;
          st_nxt.rxd = st_r.rx_sh;
        end else if (st_r.rx_bit != 4'h0) begin
          st_nxt.rx_sh = {boot_select_a_in, st_r.rx_sh[7:1]};
        end
      end
    end
    if (st_r.push_v && txq.wr_ready) begin
      st_nxt.push_v = 1'b0;
    end
    // a byte arriving while an echo is still queued for entry is dropped
    if (byte_v && !st_r.push_v) begin
      case (st_r.st)
        ST_SYNC: begin
          if (byte_d == SYNC_BYTE) begin // R17
            st_nxt.push_v = 1'b1;
            st_nxt.push_d = byte_d;
            st_nxt.st = ST_BAUD;
          end
        end
        ST_BAUD: begin
          if (code_div != '0) begin
            st_nxt.push_v = 1'b1;
            st_nxt.push_d = byte_d;
            st_nxt.div_pend = code_div; // R11 R12 R20
            st_nxt.pend = 1'b1;
            st_nxt.st = ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_d == CMD_FLASH_WR || byte_d == CMD_RAM_LOAD ||
              byte_d == CMD_FLASH_SUM) begin // R18
            st_nxt.push_v = 1'b1;
            st_nxt.push_d = byte_d;
            st_nxt.cmd = byte_d;
            st_nxt.cmd_v = 1'b1;
            st_nxt.st = ST_RUN;
          end
        end
        ST_RUN: begin
          st_nxt.run_v = 1'b1;
        end
        default: st_nxt.st = st_r.st;
      endcase
    end
    // new rate only once the baud echo has fully left the line
    if (st_r.pend && !st_r.push_v && !txq.rd_valid && !st_r.tx_busy) begin // R19
      st_nxt.div = st_r.div_pend;
      st_nxt.pend = 1'b0;
    end
    if (txq.rd_valid && txq.rd_ready) begin
      st_nxt.tx_busy = 1'b1;
      st_nxt.tx_sh = {1'b1, txq.rd_data, 1'b0}; // R9
      st_nxt.tx_bit = '0;
      st_nxt.tx_cnt = st_r.div - DIV_W'(1);
      st_nxt.tx_line = 1'b0;
    end else if (st_r.tx_busy && high_freq_clock_tick_in) begin
      if (st_r.tx_cnt != '0) begin
        st_nxt.tx_cnt = st_r.tx_cnt - DIV_W'(1);
      end else if (st_r.tx_bit == FRAME_LAST_BIT) begin
        st_nxt.tx_busy = 1'b0;
        st_nxt.tx_line = 1'b1;
      end else begin
        st_nxt.tx_bit = st_r.tx_bit + 4'h1;
        st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
        st_nxt.tx_line = st_r.tx_sh[1];
        st_nxt.tx_cnt = st_r.div - DIV_W'(1);
      end
    end
    if (err_reset_in) begin
      st_nxt.rst_cnt = ERR_RST_CYCLES; // R15
    end else if (st_r.rst_cnt != '0) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
      st_r.st <= ST_SYNC;
      st_r.div <= DIV16_9600;
      st_r.tx_line <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (cpu_wr_in && in_ram(cpu_addr_in)) begin
      ram[9'(cpu_addr_in - RAM_BASE)] <= cpu_wdata_in; // R4
    end
    rdata_r <= ram[9'(cpu_addr_in - RAM_BASE)];
  end

  assign cpu_rdata_out = rdata_r;
  assign boot_select_b_out = st_r.tx_line;
  assign boot_select_b_oe_n_out = !st_r.serial; // R7
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n_out = (st_r.rst_cnt == '0); // R15
  assign flash_sel_out = st_r.flash_sel;
  assign boot_sel_out = st_r.boot_sel;
  assign ram_sel_out = st_r.ram_sel;
  assign serial_mode_out = st_r.serial;
  assign osc_unsupported_out = st_r.osc_bad;
  assign cmd_out = st_r.cmd;
  assign cmd_valid_out = st_r.cmd_v;
  assign rx_data_out = st_r.rxd;
  assign rx_valid_out = st_r.run_v;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_boot_rom_hidden: assert property (boot_sel_out |-> serial_mode_out) // R5
    else $error("boot memory selected outside serial mode");
  a_flash_range: assert property (st_r.strap_done && !serial_mode_out &&
    $past(cpu_addr_in) >= FLASH_BASE |-> flash_sel_out) // R2
    else $error("flash not selected in its range");
  a_tx_released: assert property (!serial_mode_out |-> boot_select_b_oe_n_out) // R1
    else $error("transmit pin driven in normal mode");
  a_sync_echo: assert property (st_r.st == ST_SYNC && byte_v && !st_r.push_v |->
    ##1 (st_r.push_v == (st_r.push_d == SYNC_BYTE && $past(byte_d) == SYNC_BYTE))) // R17
    else $error("sync byte echo wrong");
  a_cmd_decode: assert property (cmd_valid_out |-> cmd_out == CMD_FLASH_WR ||
    cmd_out == CMD_RAM_LOAD || cmd_out == CMD_FLASH_SUM) // R18
    else $error("illegal command decoded");
  a_rate_quiet: assert property ($changed(st_r.div) |-> $past(!st_r.tx_busy)) // R19
    else $error("rate changed mid frame");
  a_rate_legal: assert property (st_r.pend |-> st_r.div_pend != '0) // R14
    else $error("unavailable rate accepted");
  a_stop_high: assert property ($fell(st_r.tx_busy) |-> boot_select_b_out) // R9
    else $error("frame ended without stop level");
  a_err_drive: assert property (err_reset_in |=> !reset_pin_oe_n_out [*8]) // R15
    else $error("reset pin not held for error pulse");
  a_bad_osc_mute: assert property (osc_unsupported_out |-> st_r.st == ST_MUTE) // R13
    else $error("serial mode running at unsupported frequency");

  c_sync_seen: cover property (st_r.st == ST_SYNC ##1 st_r.st == ST_BAUD);
  c_rate_switch: cover property ($fell(st_r.pend));
  c_cmd_taken: cover property (cmd_valid_out);
  c_err_reset: cover property ($fell(reset_pin_oe_n_out));
endmodule
`default_nettype wire

// ==== sbu_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// programming controller on the far side of the serial link
module sbu_host_model (
  input wire logic clk_sys_in,
  input wire logic tx_line_in,
  output logic rx_line_out
);
  // clock cycles per bit; the tick input runs every cycle, so ticks equal cycles
  int div = 208;
  logic [7:0] got_q[$];

  initial rx_line_out = 1'b1;

  // 8 data bits lsb first, no parity, one stop bit, at the rate the device uses
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk_sys_in);
    for (int i = 0; i < 10; i++) begin
      rx_line_out <= f[i];
      repeat (div) @(posedge clk_sys_in);
    end
  endtask

  // receiver samples mid bit; a frame with a low stop bit is dropped
  initial begin
    logic [7:0] v;
    forever begin
      @(negedge tx_line_in);
      repeat (div / 2) @(posedge clk_sys_in);
      if (tx_line_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (div) @(posedge clk_sys_in);
          v[i] = tx_line_in;
        end
        repeat (div) @(posedge clk_sys_in);
        if (tx_line_in === 1'b1) begin
          got_q.push_back(v);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sbu_pkg::*;
  logic clk_sys_in, nrst_in, mode_test, strap_b, err_rst, wr;
  logic [4:0] mhz;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, cmd, rxd, last_cmd, last_rx;
  logic txo, tx_oe_n, rst_o, rst_oe_n, fsel, bsel, rsel, smode, osc_bad, cmd_v, rx_v, line_a;
  wire logic line_b;
  int n_fail = 0;
  int samples_checked = 0;
  int n_cmd = 0;
  int n_rx = 0;

  // a released transmit pin rests at the strap level
  assign line_b = tx_oe_n ? strap_b : txo;

  sbu_top dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .mode_test_in(mode_test),
    .boot_select_a_in(line_a), .boot_select_b_in(line_b), .boot_select_b_out(txo),
    .boot_select_b_oe_n_out(tx_oe_n), .high_freq_clock_tick_in(1'b1),
    .high_freq_clock_mhz_in(mhz), .err_reset_in(err_rst), .reset_pin_out(rst_o),
    .reset_pin_oe_n_out(rst_oe_n), .cpu_addr_in(addr), .cpu_wr_in(wr),
    .cpu_wdata_in(wdata), .cpu_rdata_out(rdata), .flash_sel_out(fsel),
    .boot_sel_out(bsel), .ram_sel_out(rsel), .serial_mode_out(smode),
    .osc_unsupported_out(osc_bad), .cmd_out(cmd), .cmd_valid_out(cmd_v),
    .rx_data_out(rxd), .rx_valid_out(rx_v));

  sbu_host_model host_u (.clk_sys_in(clk_sys_in), .tx_line_in(line_b), .rx_line_out(line_a));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    if (cmd_v === 1'b1) begin
      last_cmd <= cmd;
      n_cmd <= n_cmd + 1;
    end
    if (rx_v === 1'b1) begin
      last_rx <= rxd;
      n_rx <= n_rx + 1;
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // straps are set while reset is low and held until after release
  task automatic boot(input logic test, input logic [4:0] f);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    mode_test <= test;
    strap_b <= 1'b1;
    mhz <= f;
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
  endtask

  task automatic sel(input logic [15:0] a, input logic f, input logic b, input logic r);
    @(posedge clk_sys_in);
    addr <= a;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk1(fsel, f);
    chk1(bsel, b);
    chk1(rsel, r);
  endtask

  task automatic ram_rw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk8(rdata, d);
  endtask

  // send one byte; an echo is either expected back whole or not at all
  task automatic xfer(input logic [7:0] b, input logic echo);
    host_u.got_q.delete();
    host_u.send(b);
    for (int i = 0; i < 14 * host_u.div && host_u.got_q.size() == 0; i++) begin
      @(posedge clk_sys_in);
    end
    chk1(host_u.got_q.size() != 0, echo);
    if (echo && host_u.got_q.size() != 0) begin
      chk8(host_u.got_q[0], b);
    end
    // let the echo's stop bit finish before a rate change
    repeat (host_u.div) @(posedge clk_sys_in);
  endtask

  task automatic t_normal;
    boot(1'b0, OSC_16MHZ);
    chk1(smode, 1'b0);
    chk1(tx_oe_n, 1'b1);
    sel(16'hC000, 1'b1, 1'b0, 1'b0);
    sel(16'hFFFF, 1'b1, 1'b0, 1'b0);
    sel(16'hBFFF, 1'b0, 1'b0, 1'b0);
    sel(RAM_BASE, 1'b0, 1'b0, 1'b1);
    sel(RAM_BASE + 16'd512, 1'b0, 1'b0, 1'b0);
    ram_rw(RAM_BASE, 8'hA5);
    ram_rw(RAM_BASE + 16'd511, 8'h5C);
  endtask

  task automatic t_err;
    logic [7:0] cnt;
    cnt = 8'h00;
    @(posedge clk_sys_in);
    err_rst <= 1'b1;
    @(posedge clk_sys_in);
    err_rst <= 1'b0;
    repeat (20) begin
      @(negedge clk_sys_in);
      if (rst_oe_n === 1'b0) cnt++;
    end
    chk8(cnt, {4'h0, ERR_RST_CYCLES});
    chk1(rst_o, 1'b0);
  endtask

  task automatic t_serial2;
    int n;
    boot(1'b1, OSC_2MHZ);
    chk1(smode, 1'b1);
    chk1(osc_bad, 1'b0);
    chk1(tx_oe_n, 1'b0);
    sel(BOOT_BASE, 1'b0, 1'b1, 1'b0);
    sel(16'hF7FF, 1'b1, 1'b0, 1'b0);
    host_u.div = 208;
    xfer(8'h11, 1'b0);
    xfer(SYNC_BYTE, 1'b1);
    xfer(BAUD_19200, 1'b0);
    xfer(BAUD_9600, 1'b1);
    n = n_cmd;
    xfer(8'h31, 1'b0);
    xfer(CMD_FLASH_WR, 1'b1);
    chk1(n_cmd == n + 1, 1'b1);
    chk8(last_cmd, CMD_FLASH_WR);
    n = n_rx;
    host_u.send(8'h3C);
    repeat (416) @(posedge clk_sys_in);
    chk8(last_rx, 8'h3C);
    chk1(n_rx == n + 1, 1'b1);
  endtask

  task automatic t_osc;
    boot(1'b1, 5'd3);
    chk1(osc_bad, 1'b1);
    host_u.div = 208;
    xfer(SYNC_BYTE, 1'b0);
  endtask

  task automatic t_serial8;
    boot(1'b1, OSC_8MHZ);
    host_u.div = 832;
    xfer(SYNC_BYTE, 1'b1);
    xfer(BAUD_62500, 1'b1);
    host_u.div = 128;
    xfer(CMD_RAM_LOAD, 1'b1);
    chk8(last_cmd, CMD_RAM_LOAD);
  endtask

  initial begin
    nrst_in = 1'b0;
    mode_test = 1'b0;
    strap_b = 1'b1;
    err_rst = 1'b0;
    wr = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    mhz = OSC_16MHZ;
    t_normal();
    t_err();
    t_serial2();
    t_osc();
    t_serial8();
    finish_test();
  end

  // the sequence needs roughly 70000 cycles
  initial begin
    #(8 * 90000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
